// ===== svd_pkg.sv
package svd_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // detector_control_reg fields
  localparam int LVL_LSB    = 0;
  localparam int LVL_W      = 4;
  localparam int PWR_BIT    = 4;
  localparam int STABLE_BIT = 5;
  localparam int CTRL_W     = 8;

  // status and irq register fields
  localparam int FLAG_BIT = 0;
  localparam int IE_BIT   = 1;
  localparam int GIE_BIT  = 2;
  localparam int VALID_BIT = 3;

  // reset values
  localparam logic [3:0] LVL_RST = 4'h5;
  localparam logic       PWR_RST = 1'b0;
  localparam logic       IE_RST  = 1'b0;
  localparam logic       GIE_RST = 1'b0;

  // special trip codes
  localparam logic [3:0] LVL_EXTERNAL = 4'hf;
  localparam logic [3:0] LVL_RESERVED = 4'h0;

  typedef enum logic [1:0] {
    SVD_OFF      = 2'b00,
    SVD_SETTLING = 2'b01,
    SVD_ARMED    = 2'b11
  } svd_state_e;

endpackage

// ===== svd_flag.sv
`timescale 1ns/1ps
module svd_flag (
  input  wire logic clk,      // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic set_i,    // trip seen this cycle
  input  wire logic clr_i,    // software clear request
  output logic      flag_o,   // sticky undervoltage flag
  output logic      rise_o    // one-cycle pulse when flag goes 0 to 1
);

  logic flag_r;

  // set beats clear in the same cycle so no trip is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end

  assign flag_o = flag_r;
  assign rise_o = set_i & ~flag_r;

endmodule

// ===== svd_top.sv
// Operation
// - trip level comes from the 4-bit limit field, control bits 3:0
// - limit code all ones routes the external analog pin to the comparator
// - codes 0001..1110 pick rising internal taps; 0000 is reserved, never trips
// - bit 4 powers the detector up; clear powers down and disables detection
// - bit 5 is read-only, set when the reference is stable and detection valid
// - flag sets when comparator says the selected tap is below the set point
// - flag cannot set until the reference is stable after enabling
// - settling wait is a fixed analog time, not counted in clocks
// - flag with its irq enable and the global irq enable requests an interrupt to the vector
// - enabled detector works in sleep; a trip sets flag and wakes device
// - after a detector wake, vector entry only if interrupts globally enabled
// - any reset returns the control register to reset value, detector off
// - control bits 7 and 6 are unimplemented and read zero
`timescale 1ns/1ps
module svd_top (
  input  wire logic        clk,             // 25 MHz system clock
  input  wire logic        rst_n,           // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction, 1 = write
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  input  wire logic [3:0]  pstrb,           // apb byte strobes
  output logic             pready,          // apb ready
  output logic [31:0]      prdata,          // apb read data
  output logic             pslverr,         // apb error on unmapped address
  input  wire logic        comp_below,      // comparator: tap below reference
  input  wire logic        ref_settled,     // analog reference has settled
  input  wire logic        sleep_mode,      // core is asleep
  output logic             power_enable,    // powers divider and comparator
  output logic [3:0]       tap_select,      // divider tap, 0 when unused
  output logic             external_sel,    // comparator reads external pin
  output logic             irq,             // interrupt request level
  output logic             wake,            // one-cycle wake pulse
  output logic             vector_entry     // one-cycle: resume at vector
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [3:0]          trip_level_select_r;
  logic                detector_power_enable_r;
  logic                undervoltage_irq_enable_r;
  logic                global_irq_enable_r;
  svd_pkg::svd_state_e state_r;
  svd_pkg::svd_state_e state_nxt;

  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        power_enable_r;
  logic [3:0]  tap_select_r;
  logic        external_sel_r;
  logic        irq_r;
  logic        wake_r;
  logic        vector_entry_r;

  logic        undervoltage_flag;
  logic        flag_rise;
  logic        trip_set;
  logic        flag_clr;
  logic        reference_stable_flag;
  logic        level_valid;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup_ph;
  logic wr_cycle;
  logic hit_ctrl;
  logic hit_status;
  logic wr_ctrl;
  logic wr_status;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign setup_ph   = psel & ~penable;
  assign wr_cycle   = psel & penable & pready_r & pwrite;
  assign hit_ctrl   = addr_is(paddr, svd_pkg::CTRL_OFS);
  assign hit_status = addr_is(paddr, svd_pkg::STATUS_OFS);
  // only the low byte holds fields, so only lane 0 matters
  assign wr_ctrl    = wr_cycle & hit_ctrl & pstrb[0];
  assign wr_status  = wr_cycle & hit_status & pstrb[0];

  // ---------------------------------------------------------------
  // limit code decode
  // ---------------------------------------------------------------
  function automatic logic code_is_tap(input logic [3:0] c);
    code_is_tap = (c != svd_pkg::LVL_RESERVED) && (c != svd_pkg::LVL_EXTERNAL);
  endfunction

  // reserved code gives no valid trip setting
  assign level_valid = (trip_level_select_r != svd_pkg::LVL_RESERVED);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_level_select_r <= svd_pkg::LVL_RST;
    end else if (wr_ctrl) begin
      trip_level_select_r <= pwdata[svd_pkg::LVL_LSB +: svd_pkg::LVL_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_power_enable_r <= svd_pkg::PWR_RST;
    end else if (wr_ctrl) begin
      detector_power_enable_r <= pwdata[svd_pkg::PWR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // status and interrupt enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undervoltage_irq_enable_r <= svd_pkg::IE_RST;
      global_irq_enable_r       <= svd_pkg::GIE_RST;
    end else if (wr_status) begin
      undervoltage_irq_enable_r <= pwdata[svd_pkg::IE_BIT];
      global_irq_enable_r       <= pwdata[svd_pkg::GIE_BIT];
    end
  end

  // write one to the flag bit clears it
  assign flag_clr = wr_status & pwdata[svd_pkg::FLAG_BIT];

  // ---------------------------------------------------------------
  // reference settling
  // the wait is an analog time, so the block waits on the
  // settled level from the reference instead of counting clocks
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      svd_pkg::SVD_OFF: begin
        if (detector_power_enable_r) begin
          state_nxt = svd_pkg::SVD_SETTLING;
        end
      end
      svd_pkg::SVD_SETTLING: begin
        if (!detector_power_enable_r) begin
          state_nxt = svd_pkg::SVD_OFF;
        end else if (ref_settled) begin
          state_nxt = svd_pkg::SVD_ARMED;
        end
      end
      svd_pkg::SVD_ARMED: begin
        if (!detector_power_enable_r) begin
          state_nxt = svd_pkg::SVD_OFF;
        end
      end
      default: begin
        state_nxt = svd_pkg::SVD_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= svd_pkg::SVD_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reference_stable_flag = (state_r == svd_pkg::SVD_ARMED);

  // ---------------------------------------------------------------
  // detection
  // sleep does not gate the trip: the detector keeps running
  // ---------------------------------------------------------------
  // power bit gates at once: the state machine only leaves ARMED an edge later
  assign trip_set = detector_power_enable_r
                  & reference_stable_flag
                  & level_valid
                  & comp_below;

  svd_flag u_flag (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_i  (trip_set),
    .clr_i  (flag_clr),
    .flag_o (undervoltage_flag),
    .rise_o (flag_rise)
  );

  // ---------------------------------------------------------------
  // analog controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_enable_r <= 1'b0;
    end else begin
      power_enable_r <= detector_power_enable_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_select_r <= 4'h0;
    end else if (code_is_tap(trip_level_select_r)) begin
      tap_select_r <= trip_level_select_r;
    end else begin
      tap_select_r <= 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_sel_r <= 1'b0;
    end else begin
      external_sel_r <= (trip_level_select_r == svd_pkg::LVL_EXTERNAL);
    end
  end

  // ---------------------------------------------------------------
  // interrupt, wake and vector entry
  // ---------------------------------------------------------------
  logic irq_nxt;
  assign irq_nxt = (undervoltage_flag | trip_set)
                 & undervoltage_irq_enable_r
                 & global_irq_enable_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // a trip in sleep wakes the core whatever the enables say
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= flag_rise & sleep_mode;
    end
  end

  // without global enable the core simply continues after sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_entry_r <= 1'b0;
    end else begin
      vector_entry_r <= flag_rise & sleep_mode
                      & undervoltage_irq_enable_r
                      & global_irq_enable_r;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: no wait state, read data leaves a flop loaded in the setup phase
  // ---------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_val[svd_pkg::LVL_LSB +: svd_pkg::LVL_W] = trip_level_select_r;
      rd_val[svd_pkg::PWR_BIT]    = detector_power_enable_r;
      rd_val[svd_pkg::STABLE_BIT] = reference_stable_flag;
      // bits 7:6 and above stay zero
    end else if (hit_status) begin
      rd_val[svd_pkg::FLAG_BIT]  = undervoltage_flag;
      rd_val[svd_pkg::IE_BIT]    = undervoltage_irq_enable_r;
      rd_val[svd_pkg::GIE_BIT]   = global_irq_enable_r;
      rd_val[svd_pkg::VALID_BIT] = level_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_val;
    end else if (!psel) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= ~(hit_ctrl | hit_status);
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  assign pready       = pready_r;
  assign prdata       = prdata_r;
  assign pslverr      = pslverr_r;
  assign power_enable = power_enable_r;
  assign tap_select   = tap_select_r;
  assign external_sel = external_sel_r;
  assign irq          = irq_r;
  assign wake         = wake_r;
  assign vector_entry = vector_entry_r;

endmodule

// ===== svd_analog_model.sv
`timescale 1ns/1ps
module svd_analog_model #(
  parameter int SETTLE = 6          // stands in for the fixed analog settling time
) (
  input  wire logic clk,            // system clock
  input  wire logic rst_n,          // async reset, active low
  input  wire logic power_enable,   // detector powered
  input  wire logic supply_low,     // bench: supply under the chosen trip point
  input  wire logic noise,          // bench: chatter of an unsettled comparator
  output logic      comp_below,     // comparator output
  output logic      ref_settled     // reference stable
);
  int cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt <= 0;
    else if (!power_enable)
      cnt <= 0;
    else if (cnt < SETTLE)
      cnt <= cnt + 1;
  end

  assign ref_settled = power_enable && cnt == SETTLE;
  // unpowered or settling comparator chatters, the design must ignore it
  assign comp_below = ref_settled ? supply_low : noise;
endmodule

// ===== svd_assertions.sv
`timescale 1ns/1ps
module svd_checker (
  input wire logic        clk,          // system clock
  input wire logic        rst_n,        // async reset
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb access
  input wire logic        pwrite,       // apb direction
  input wire logic [7:0]  paddr,        // apb address
  input wire logic        pready,       // apb ready
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pslverr,      // apb error
  input wire logic        comp_below,   // comparator
  input wire logic        sleep_mode,   // core asleep
  input wire logic        power_enable, // detector power
  input wire logic [3:0]  tap_select,   // divider tap
  input wire logic        external_sel, // external pin
  input wire logic        irq,          // interrupt
  input wire logic        wake,         // wake pulse
  input wire logic        vector_entry  // vector pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ext_no_tap_a: assert property (external_sel |-> tap_select == 4'h0)
    else $error("tap selected with external input");
  ctrl_high_zero_a: assert property (pready && !pwrite && paddr == svd_pkg::CTRL_OFS
    |-> prdata[31:6] == 26'h0) else $error("unimplemented bits read nonzero");
  stable_needs_power_a: assert property (pready && !pwrite
    && paddr == svd_pkg::CTRL_OFS && prdata[5] |-> power_enable)
    else $error("stable while powered down");
  wake_cause_a: assert property (wake |-> $past(comp_below) && $past(sleep_mode))
    else $error("wake without trip in sleep");
  wake_pulse_a: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  vector_needs_wake_a: assert property (vector_entry |-> wake)
    else $error("vector entry without wake");
  irq_cause_a: assert property ($rose(irq) |-> $past(comp_below)
    || $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("irq rose without trip or write");
endmodule

bind svd_top svd_checker i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .comp_below(comp_below), .sleep_mode(sleep_mode), .power_enable(power_enable),
  .tap_select(tap_select), .external_sel(external_sel), .irq(irq), .wake(wake),
  .vector_entry(vector_entry));

// ===== low_voltage_detect_control_test.sv
`timescale 1ns/1ps
module low_voltage_detect_control_test;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sleep_mode = 0, supply_low = 0, noise = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, d, rdq;
  logic [3:0]  pstrb = 4'h0, tap_select;
  logic        pready, pslverr, comp_below, ref_settled, power_enable;
  logic        external_sel, irq, wake, vector_entry, rerr;
  logic [31:0] prdata;
  int          n_mismatch = 0, check_count = 0, seed = 65635, n;
  localparam logic [7:0] CT = svd_pkg::CTRL_OFS;
  localparam logic [7:0] ST = svd_pkg::STATUS_OFS;

  always #20 clk = ~clk;
  always @(posedge clk) noise <= ~noise;

  svd_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comp_below(comp_below), .ref_settled(ref_settled),
    .sleep_mode(sleep_mode), .power_enable(power_enable), .tap_select(tap_select),
    .external_sel(external_sel), .irq(irq), .wake(wake), .vector_entry(vector_entry));
  svd_analog_model i_ana (.clk(clk), .rst_n(rst_n), .power_enable(power_enable),
    .supply_low(supply_low), .noise(noise), .comp_below(comp_below),
    .ref_settled(ref_settled));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one idle edge after each transfer so no signal is driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_mismatch++;
    rdq = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] st_exp(logic f, logic ie, logic g, logic [3:0] l);
    return {28'h0, l != 4'h0, g, ie, f};
  endfunction
  function automatic logic [31:0] tap_exp(logic [3:0] l);
    return (l == 4'h0 || l == 4'hf) ? 32'h0 : {28'h0, l};
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, CT, 0); chk(rdq, 32'h05);
    apb(0, ST, 0); chk(rdq, st_exp(0, 0, 0, 4'h5));
    apb(0, 8'h08, 0); chk(32'(rerr), 32'h1);
    $display("test reset done");
    supply_low <= 1;
    for (int c = 0; c < 16; c++) begin
      d = $random(seed);
      apb(1, CT, {d[31:8], 3'b111, 1'b0, 4'(c)});
      apb(0, CT, 0); chk(rdq, 32'(c));
      chk(32'(tap_select), tap_exp(4'(c)));
      chk(32'(external_sel), 32'(c == 15));
    end
    apb(0, ST, 0); chk(rdq, st_exp(0, 0, 0, 4'hf));
    $display("test limit codes done");
    supply_low <= 0;
    apb(1, CT, 32'h0a);
    apb(1, CT, 32'h1a);
    apb(0, CT, 0); chk(rdq, 32'h1a);
    n = 0;
    do apb(0, CT, 0); while (rdq[5] !== 1'b1 && ++n < 20);
    chk(rdq, 32'h3a);
    apb(0, ST, 0); chk(rdq, st_exp(0, 0, 0, 4'ha));
    apb(1, ST, 32'h1);
    apb(1, ST, 32'h6);
    chk(32'(irq), 32'h0);
    supply_low <= 1;
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    supply_low <= 0;
    apb(0, ST, 0); chk(rdq, st_exp(1, 1, 1, 4'ha));
    apb(1, ST, 32'h7);
    apb(0, ST, 0); chk(rdq, st_exp(0, 1, 1, 4'ha));
    chk(32'(irq), 32'h0);
    $display("test detect done");
    for (int g = 1; g >= 0; g--) begin
      sleep_mode <= 1;
      supply_low <= 1;
      n = 0;
      do @(posedge clk); while (wake !== 1'b1 && ++n < 10);
      chk(32'(wake), 32'h1);
      chk(32'(vector_entry), 32'(g));
      chk(32'(irq), 32'(g));
      supply_low <= 0;
      sleep_mode <= 0;
      apb(1, ST, 32'h3);
    end
    $display("test sleep done");
    apb(1, CT, 32'h10);
    supply_low <= 1;
    repeat (4) @(posedge clk);
    apb(0, ST, 0); chk(rdq, st_exp(0, 1, 0, 4'h0));
    apb(1, CT, 32'h0a);
    repeat (5) @(posedge clk);
    apb(0, ST, 0); chk(rdq, st_exp(0, 1, 0, 4'ha));
    chk(32'(power_enable), 32'h0);
    apb(1, CT, 32'h1c);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, CT, 0); chk(rdq, 32'h05);
    chk(32'(power_enable), 32'h0);
    $display("test power and reset done");
    print_verdict();
  end
endmodule
